// ### inc/logic_net_pkg.sv
// Constants, register map and carrier types for the configurable logic network.
// Assumes one clock, an APB master and same-clock status signals around it.
//
// Summary of operation
// - Gate sources A, B, C reset to unused.
// - Active gate with A unused raises alarm.
// - Active gate with B and C unused alarms.
// - Active gate with C unused and inverted alarms.
// - One-cycle pulse sets or clears a latch.
// - Latches start cleared after power returns.
// - Reset-dominant: reset edge wins over set.
// - Latch set and reset sources reset unused.
// - Active latch with set unused alarms.
// - Active latch with reset unused alarms.
// - Source codes map to constants, inputs, outputs.
// - AND all used high; OR any high.
// - Equal same level; unequal levels differ.
package logic_net_pkg;

    // ----------------------------------------------------------------
    // Source catalogue
    // ----------------------------------------------------------------
    localparam int SEL_W = 7;
    localparam logic [SEL_W-1:0] SRC_UNUSED = 7'h00;
    localparam logic [SEL_W-1:0] SRC_LOW = 7'h01;
    localparam logic [SEL_W-1:0] SRC_HIGH = 7'h02;
    localparam logic [SEL_W-1:0] SRC_DI_BASE = 7'h3F;
    localparam logic [SEL_W-1:0] SRC_GATE_BASE = 7'h56;
    localparam logic [SEL_W-1:0] SRC_LATCH_BASE = 7'h5E;
    localparam logic [SEL_W-1:0] SRC_TIMER_BASE = 7'h62;
    localparam int FIRST_GATE = 2;
    localparam int NUM_GATES = 5;
    localparam int NUM_LATCHES = 2;

    // ----------------------------------------------------------------
    // Function codes
    // ----------------------------------------------------------------
    localparam logic [2:0] FN_AND = 3'h1;
    localparam logic [2:0] FN_OR = 3'h2;
    localparam logic [2:0] FN_EQUAL = 3'h3;
    localparam logic [2:0] FN_UNEQUAL = 3'h4;
    localparam logic [2:0] FN_SET_DOM = 3'h1;
    localparam logic [2:0] FN_RESET_DOM = 3'h2;

    // ----------------------------------------------------------------
    // Register map (byte addresses) and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_GATE_BASE = 8'h00;
    localparam logic [7:0] ADDR_LATCH_BASE = 8'h20;
    localparam logic [7:0] ADDR_STATE = 8'h30;
    localparam logic [7:0] ADDR_EVT_STAT = 8'h34;
    localparam logic [7:0] ADDR_EVT_MASK = 8'h38;
    localparam int POS_EN = 0;
    localparam int POS_FN = 1;
    localparam int POS_REV = 4;
    localparam int POS_CINV = 5;
    localparam int POS_SEL_A = 8;
    localparam int POS_SEL_B = 16;
    localparam int POS_SEL_C = 24;
    localparam int POS_LATCH_Q = 8;
    localparam int POS_ALARM = 16;
    localparam int EVT_W = 3;
    localparam int EVT_ALARM = 2;

    // ----------------------------------------------------------------
    // Carrier types and reset values
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [SEL_W-1:0] sel_c;
        logic [SEL_W-1:0] sel_b;
        logic [SEL_W-1:0] sel_a;
        logic cinv;
        logic rev;
        logic [2:0] fn;
        logic en;
    } gate_cfg_t;

    typedef struct packed {
        logic [SEL_W-1:0] sel_r;
        logic [SEL_W-1:0] sel_s;
        logic [2:0] fn;
        logic en;
    } latch_cfg_t;

    localparam gate_cfg_t GATE_CFG_RST = '{sel_c: SRC_UNUSED, sel_b: SRC_UNUSED,
        sel_a: SRC_UNUSED, cinv: 1'b0, rev: 1'b0, fn: FN_AND, en: 1'b0};
    localparam latch_cfg_t LATCH_CFG_RST = '{sel_r: SRC_UNUSED, sel_s: SRC_UNUSED,
        fn: FN_SET_DOM, en: 1'b0};
    localparam logic [EVT_W-1:0] EVT_MASK_RST = 3'h0;

endpackage : logic_net_pkg

// ### logic/logic_net.sv
// Configurable gate and latch network with APB configuration registers.
// Assumes EXT_I comes from logic on CLK_I; DI_I comes from pins and is resynchronised.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module logic_net
    import logic_net_pkg::*;
#(
    parameter int NUM_DI = 5
) (
    // Clock, reset, enable
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Signal sources
    input wire logic [127:0] EXT_I,
    input wire logic [NUM_DI-1:0] DI_I,
    // Results
    output logic [NUM_GATES-1:0] GATE_OUT_O,
    output logic [NUM_LATCHES-1:0] LATCH_OUT_O,
    output logic CFG_ALARM_O,
    output logic IRQ_O
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    // Digital inputs must not run into the comparator codes
    if (NUM_DI < 1 || NUM_DI > 17) begin : g_bad_di
        $error("NUM_DI out of range");
    end

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic pick(input logic [127:0] srcs, input logic [SEL_W-1:0] sel);
        pick = srcs[sel];
    endfunction : pick

    function automatic logic combine(input logic [2:0] used, input logic [2:0] v,
                                     input logic [2:0] fn);
        logic [2:0] m;
        m = v & used;
        unique case (fn)
            FN_AND: combine = (m == used);
            FN_OR: combine = (m != 3'h0);
            FN_EQUAL: combine = (m == used) || (m == 3'h0);
            FN_UNEQUAL: combine = !((m == used) || (m == 3'h0));
            default: combine = 1'b0;
        endcase
    endfunction : combine

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    gate_cfg_t gate_cfg_reg [NUM_GATES];
    latch_cfg_t latch_cfg_reg [NUM_LATCHES];
    logic [NUM_GATES-1:0] gate_q_reg;
    logic [NUM_GATES-1:0] gate_q_next;
    logic [NUM_LATCHES-1:0] latch_q_reg;
    logic [NUM_LATCHES-1:0] latch_q_next;
    logic [NUM_LATCHES-1:0] set_prev_reg;
    logic [NUM_LATCHES-1:0] rst_prev_reg;
    logic [NUM_LATCHES-1:0] set_now;
    logic [NUM_LATCHES-1:0] rst_now;
    logic [NUM_DI-1:0] di_s1_reg;
    logic [NUM_DI-1:0] di_s2_reg;
    logic [NUM_DI-1:0] di_s3_reg;
    logic [NUM_DI-1:0] di_reg;
    logic alarm_reg;
    logic alarm_next;
    logic [EVT_W-1:0] evt_stat_reg;
    logic [EVT_W-1:0] evt_mask_reg;
    logic [EVT_W-1:0] evt_set;
    logic [127:0] srcs;
    logic wr_en;
    logic rd_en;
    logic stat_rd;
    logic [31:0] rdata_next;
    logic addr_ok;

    // ----------------------------------------------------------------
    // Digital input resynchroniser
    // ----------------------------------------------------------------
    // A level counts only once the second and third stages agree
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            di_s1_reg <= '0;
            di_s2_reg <= '0;
            di_s3_reg <= '0;
            di_reg <= '0;
        end else if (CE_I) begin
            di_s1_reg <= DI_I;
            di_s2_reg <= di_s1_reg;
            di_s3_reg <= di_s2_reg;
            for (int i = 0; i < NUM_DI; i++) begin
                if (di_s2_reg[i] == di_s3_reg[i]) begin
                    di_reg[i] <= di_s3_reg[i];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Source catalogue
    // ----------------------------------------------------------------
    // Feedback codes see last cycle's outputs, so loops never go combinational
    always_comb begin
        srcs = EXT_I;
        srcs[SRC_UNUSED] = 1'b0;
        srcs[SRC_LOW] = 1'b0;
        srcs[SRC_HIGH] = 1'b1;
        for (int i = 0; i < NUM_DI; i++) begin
            srcs[int'(SRC_DI_BASE) + i] = di_reg[i];
        end
        for (int i = 0; i < NUM_GATES; i++) begin
            srcs[int'(SRC_GATE_BASE) + FIRST_GATE - 1 + i] = gate_q_reg[i];
        end
        for (int i = 0; i < NUM_LATCHES; i++) begin
            srcs[int'(SRC_LATCH_BASE) + i] = latch_q_reg[i];
        end
    end

    // ----------------------------------------------------------------
    // Gate evaluation and configuration check
    // ----------------------------------------------------------------
    always_comb begin
        logic [2:0] used;
        logic [2:0] v;
        used = 3'h0;
        v = 3'h0;
        alarm_next = 1'b0;
        for (int i = 0; i < NUM_GATES; i++) begin
            used = {gate_cfg_reg[i].sel_c != SRC_UNUSED, gate_cfg_reg[i].sel_b != SRC_UNUSED,
                    gate_cfg_reg[i].sel_a != SRC_UNUSED};
            v = {pick(srcs, gate_cfg_reg[i].sel_c) ^ gate_cfg_reg[i].cinv,
                 pick(srcs, gate_cfg_reg[i].sel_b), pick(srcs, gate_cfg_reg[i].sel_a)};
            gate_q_next[i] = gate_cfg_reg[i].en
                && (combine(used, v, gate_cfg_reg[i].fn) ^ gate_cfg_reg[i].rev);
            if (gate_cfg_reg[i].en) begin
                if (!used[0]) begin
                    alarm_next = 1'b1;
                end
                if (!used[1] && !used[2]) begin
                    alarm_next = 1'b1;
                end
                if (!used[2] && gate_cfg_reg[i].cinv) begin
                    alarm_next = 1'b1;
                end
            end
        end
        for (int j = 0; j < NUM_LATCHES; j++) begin
            if (latch_cfg_reg[j].en && latch_cfg_reg[j].sel_s == SRC_UNUSED) begin
                alarm_next = 1'b1;
            end
            if (latch_cfg_reg[j].en && latch_cfg_reg[j].sel_r == SRC_UNUSED) begin
                alarm_next = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Latch evaluation
    // ----------------------------------------------------------------
    always_comb begin
        for (int j = 0; j < NUM_LATCHES; j++) begin
            set_now[j] = pick(srcs, latch_cfg_reg[j].sel_s);
            rst_now[j] = pick(srcs, latch_cfg_reg[j].sel_r);
            latch_q_next[j] = latch_q_reg[j];
            if (!latch_cfg_reg[j].en) begin
                latch_q_next[j] = 1'b0;
            end else if (latch_cfg_reg[j].fn == FN_RESET_DOM) begin
                if (rst_now[j] && !rst_prev_reg[j]) begin
                    latch_q_next[j] = 1'b0;
                end else if (set_now[j] && !set_prev_reg[j] && !rst_now[j]) begin
                    latch_q_next[j] = 1'b1;
                end
            end else if (latch_cfg_reg[j].fn == FN_SET_DOM) begin
                if (set_now[j] && !set_prev_reg[j]) begin
                    latch_q_next[j] = 1'b1;
                end else if (rst_now[j] && !rst_prev_reg[j] && !set_now[j]) begin
                    latch_q_next[j] = 1'b0;
                end
            end
        end
    end

    // No remanence: the only retained state is cleared by reset
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            gate_q_reg <= '0;
            latch_q_reg <= '0;
            set_prev_reg <= '0;
            rst_prev_reg <= '0;
            alarm_reg <= 1'b0;
        end else if (CE_I) begin
            gate_q_reg <= gate_q_next;
            latch_q_reg <= latch_q_next;
            set_prev_reg <= set_now;
            rst_prev_reg <= rst_now;
            alarm_reg <= alarm_next;
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Zero wait states while CE_I is high; unmapped addresses answer with an error and read zero
    assign wr_en = PSEL && PENABLE && PWRITE && CE_I;
    assign rd_en = PSEL && PENABLE && !PWRITE && CE_I;
    assign stat_rd = rd_en && PADDR == ADDR_EVT_STAT;
    assign PREADY = CE_I;

    always_comb begin
        rdata_next = 32'h0000_0000;
        addr_ok = 1'b1;
        if (PADDR[1:0] != 2'h0) begin
            addr_ok = 1'b0;
        end else if (PADDR < ADDR_GATE_BASE + 8'(4 * NUM_GATES)) begin
            rdata_next = {1'b0, gate_cfg_reg[PADDR[4:2]].sel_c, 1'b0,
                gate_cfg_reg[PADDR[4:2]].sel_b, 1'b0, gate_cfg_reg[PADDR[4:2]].sel_a,
                2'h0, gate_cfg_reg[PADDR[4:2]].cinv, gate_cfg_reg[PADDR[4:2]].rev,
                gate_cfg_reg[PADDR[4:2]].fn, gate_cfg_reg[PADDR[4:2]].en};
        end else if (PADDR >= ADDR_LATCH_BASE
                     && PADDR < ADDR_LATCH_BASE + 8'(4 * NUM_LATCHES)) begin
            rdata_next = {9'h000, latch_cfg_reg[PADDR[2]].sel_r, 1'b0,
                latch_cfg_reg[PADDR[2]].sel_s, 4'h0, latch_cfg_reg[PADDR[2]].fn,
                latch_cfg_reg[PADDR[2]].en};
        end else if (PADDR == ADDR_STATE) begin
            rdata_next[NUM_GATES-1:0] = gate_q_reg;
            rdata_next[POS_LATCH_Q +: NUM_LATCHES] = latch_q_reg;
            rdata_next[POS_ALARM] = alarm_reg;
        end else if (PADDR == ADDR_EVT_STAT) begin
            rdata_next[EVT_W-1:0] = evt_stat_reg;
        end else if (PADDR == ADDR_EVT_MASK) begin
            rdata_next[EVT_W-1:0] = evt_mask_reg;
        end else begin
            addr_ok = 1'b0;
        end
    end

    assign PSLVERR = PSEL && PENABLE && !addr_ok;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && CE_I) begin
            PRDATA <= rdata_next;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int i = 0; i < NUM_GATES; i++) begin
                gate_cfg_reg[i] <= GATE_CFG_RST;
            end
            for (int j = 0; j < NUM_LATCHES; j++) begin
                latch_cfg_reg[j] <= LATCH_CFG_RST;
            end
            evt_mask_reg <= EVT_MASK_RST;
        end else if (wr_en && addr_ok) begin
            if (PADDR < ADDR_GATE_BASE + 8'(4 * NUM_GATES)) begin
                gate_cfg_reg[PADDR[4:2]] <= '{sel_c: PWDATA[POS_SEL_C +: SEL_W],
                    sel_b: PWDATA[POS_SEL_B +: SEL_W], sel_a: PWDATA[POS_SEL_A +: SEL_W],
                    cinv: PWDATA[POS_CINV], rev: PWDATA[POS_REV],
                    fn: PWDATA[POS_FN +: 3], en: PWDATA[POS_EN]};
            end else if (PADDR >= ADDR_LATCH_BASE
                         && PADDR < ADDR_LATCH_BASE + 8'(4 * NUM_LATCHES)) begin
                latch_cfg_reg[PADDR[2]] <= '{sel_r: PWDATA[POS_SEL_B +: SEL_W],
                    sel_s: PWDATA[POS_SEL_A +: SEL_W], fn: PWDATA[POS_FN +: 3],
                    en: PWDATA[POS_EN]};
            end else if (PADDR == ADDR_EVT_MASK) begin
                evt_mask_reg <= PWDATA[EVT_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Events and interrupt
    // ----------------------------------------------------------------
    // Read data is taken in the setup cycle, so only the bits it reported are cleared;
    // an event that lands in the setup or access cycle survives the read-clear
    assign evt_set = {alarm_next && !alarm_reg, latch_q_next & ~latch_q_reg};

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            evt_stat_reg <= '0;
        end else if (CE_I) begin
            evt_stat_reg <= (stat_rd ? evt_stat_reg & ~PRDATA[EVT_W-1:0] : evt_stat_reg)
                | evt_set;
        end
    end

    assign IRQ_O = |(evt_stat_reg & evt_mask_reg);
    assign GATE_OUT_O = gate_q_reg;
    assign LATCH_OUT_O = latch_q_reg;
    assign CFG_ALARM_O = alarm_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    inactive_gate_low_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && !gate_cfg_reg[0].en |=> !GATE_OUT_O[0])
        else $error("inactive gate output not low");
    gate_a_unused_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && gate_cfg_reg[0].en && gate_cfg_reg[0].sel_a == SRC_UNUSED |=> CFG_ALARM_O)
        else $error("alarm missing for unused A");
    gate_bc_unused_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && gate_cfg_reg[0].en && gate_cfg_reg[0].sel_b == SRC_UNUSED
        && gate_cfg_reg[0].sel_c == SRC_UNUSED |=> CFG_ALARM_O)
        else $error("alarm missing for unused B and C");
    gate_cinv_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && gate_cfg_reg[0].en && gate_cfg_reg[0].cinv
        && gate_cfg_reg[0].sel_c == SRC_UNUSED |=> CFG_ALARM_O)
        else $error("alarm missing for inverted unused C");
    latch_set_unused_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && latch_cfg_reg[0].en && latch_cfg_reg[0].sel_s == SRC_UNUSED |=> CFG_ALARM_O)
        else $error("alarm missing for unused set");
    latch_rst_unused_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && latch_cfg_reg[0].en && latch_cfg_reg[0].sel_r == SRC_UNUSED |=> CFG_ALARM_O)
        else $error("alarm missing for unused reset");
    set_dominant_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && latch_cfg_reg[0].en && latch_cfg_reg[0].fn == FN_SET_DOM
        && set_now[0] && !set_prev_reg[0] |=> LATCH_OUT_O[0])
        else $error("set edge did not set latch");
    reset_dominant_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && latch_cfg_reg[1].en && latch_cfg_reg[1].fn == FN_RESET_DOM
        && rst_now[1] && !rst_prev_reg[1] |=> !LATCH_OUT_O[1])
        else $error("reset edge did not clear latch");
    latch_cold_a: assert property (@(posedge CLK_I)
        $fell(RST_I) |-> LATCH_OUT_O == '0)
        else $error("latch not cleared after reset");
    const_high_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        CE_I && gate_cfg_reg[0].en && gate_cfg_reg[0].fn == FN_AND && !gate_cfg_reg[0].rev
        && gate_cfg_reg[0].sel_a == SRC_HIGH && gate_cfg_reg[0].sel_b == SRC_HIGH
        && gate_cfg_reg[0].sel_c == SRC_UNUSED |=> GATE_OUT_O[0])
        else $error("constant high source not seen");

endmodule : logic_net

// ### tb/tb_logic_net.sv
// Self-checking bench for the configurable gate and latch network.
// Assumes logic_net with zero-wait APB and read data registered in the setup cycle.
`timescale 1ns/100ps
module tb_logic_net
    import logic_net_pkg::*;
;
`define CHK(got, want) begin num_checks++; if ((got) !== (want)) begin failures++; \
    $display("wrong value at %0t: got %h want %h", $time, got, want); end end
    // ----------------------------------------------------------------
    // Signals and design
    // ----------------------------------------------------------------
    logic CLK_I, RST_I, CE_I, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, CFG_ALARM_O, IRQ_O;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic [127:0] EXT_I;
    logic [4:0] DI_I, GATE_OUT_O;
    logic [1:0] LATCH_OUT_O;
    logic [33:0] notes[$];
    logic [33:0] got_note;
    logic [4:0] g;
    logic [7:0] outs;
    int failures = 0;
    int num_checks = 0;
    logic_net #(.NUM_DI(5)) dut (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_I(EXT_I),
        .DI_I(DI_I), .GATE_OUT_O(GATE_OUT_O), .LATCH_OUT_O(LATCH_OUT_O),
        .CFG_ALARM_O(CFG_ALARM_O), .IRQ_O(IRQ_O));
    initial begin
        CLK_I = 1'b0;
        forever #50 CLK_I = ~CLK_I;
    end
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] gw(input logic [2:0] fn, input logic rev, input logic cinv,
        input logic [6:0] a, input logic [6:0] b, input logic [6:0] c);
        gw = {1'b0, c, 1'b0, b, 1'b0, a, 2'b00, cinv, rev, fn, 1'b1};
    endfunction : gw
    function automatic logic [31:0] lw(input logic [2:0] fn, input logic [6:0] s,
        input logic [6:0] r);
        lw = {9'h000, r, 1'b0, s, 4'h0, fn, 1'b1};
    endfunction : lw
    function automatic logic [33:0] st(input logic irq, input logic [1:0] l, input logic al);
        st = {irq, 1'b0, 15'h0000, al, 6'h00, l, 3'h0, g};
    endfunction : st
    // Whole APB transfer; the request stands until PREADY is seen high, then one
    // idle cycle so that no strobe is driven twice in one time step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_I);
        PENABLE <= 1'b1;
        do @(posedge CLK_I); while (PREADY !== 1'b1);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK_I);
    endtask : apb
    // Settling time covers the registered alarm and the event bit behind it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (3) @(posedge CLK_I);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        notes.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd
    // Latch sources: EXT_I[6] is set, EXT_I[7] is reset, one cycle at rs_now
    task automatic drive(input logic [1:0] rs_now, input logic [1:0] rs_after);
        EXT_I[7:6] <= rs_now;
        @(posedge CLK_I);
        EXT_I[7:6] <= rs_after;
        repeat (4) @(posedge CLK_I);
    endtask : drive
    task automatic test_done();
        $display("checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done
    // ----------------------------------------------------------------
    // Monitor and watchdog
    // ----------------------------------------------------------------
    always @(posedge CLK_I) begin
        if (PSEL && PENABLE && PREADY && !PWRITE) begin
            got_note = notes.pop_front();
            `CHK({IRQ_O, PSLVERR, PRDATA}, got_note)
            // The result pins must agree with the settled state word
            if (PADDR == ADDR_STATE) begin
                outs = {got_note[16], got_note[9:8], got_note[4:0]};
                `CHK({CFG_ALARM_O, LATCH_OUT_O, GATE_OUT_O}, outs)
            end
        end
    end
    initial begin
        repeat (20000) @(posedge CLK_I);
        failures++;
        test_done();
    end
    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hD2BF));
        {RST_I, CE_I, PSEL, PENABLE, PWRITE} = 5'b11000;
        PADDR = 8'h00;
        PWDATA = 32'h0000_0000;
        EXT_I = '0;
        DI_I = 5'h00;
        g = 5'h00;
        repeat (8) @(posedge CLK_I);
        RST_I <= 1'b0;
        @(posedge CLK_I);
        rd(ADDR_GATE_BASE, 34'h2);
        rd(ADDR_LATCH_BASE, 34'h2);
        rd(ADDR_STATE, st(1'b0, 2'b00, 1'b0));
        rd(8'h14, {2'b01, 32'h0000_0000});
        rd(8'h3C, {2'b01, 32'h0000_0000});
        // Alarm as interrupt, then cleared by reading the events
        wr(ADDR_EVT_MASK, 32'h0000_0004);
        wr(ADDR_GATE_BASE, 32'h0000_0003);
        // With no used input the AND holds vacuously, so the active gate reads high
        g = 5'h01;
        rd(ADDR_STATE, st(1'b1, 2'b00, 1'b1));
        g = 5'h00;
        rd(ADDR_EVT_STAT, {2'b10, 32'h0000_0004});
        rd(ADDR_EVT_STAT, 34'h0);
        wr(ADDR_GATE_BASE, gw(FN_AND, 1'b0, 1'b0, 7'h03, SRC_UNUSED, SRC_UNUSED));
        rd(ADDR_STATE, st(1'b0, 2'b00, 1'b1));
        wr(ADDR_GATE_BASE, gw(FN_AND, 1'b0, 1'b1, 7'h03, 7'h04, SRC_UNUSED));
        rd(ADDR_STATE, st(1'b0, 2'b00, 1'b1));
        wr(ADDR_GATE_BASE, gw(FN_AND, 1'b0, 1'b0, 7'h03, 7'h04, SRC_UNUSED));
        rd(ADDR_STATE, st(1'b0, 2'b00, 1'b0));
        // Masked: the alarm event is kept but the interrupt stays low
        wr(ADDR_EVT_MASK, 32'h0000_0000);
        wr(ADDR_LATCH_BASE, lw(FN_SET_DOM, SRC_UNUSED, 7'h07));
        rd(ADDR_STATE, st(1'b0, 2'b00, 1'b1));
        wr(ADDR_LATCH_BASE, lw(FN_SET_DOM, 7'h06, SRC_UNUSED));
        rd(ADDR_STATE, st(1'b0, 2'b00, 1'b1));
        rd(ADDR_EVT_STAT, {2'b00, 32'h0000_0004});
        // All gate functions on shared sources, random levels
        wr(ADDR_GATE_BASE, gw(FN_AND, 1'b0, 1'b0, 7'h03, 7'h04, 7'h05));
        wr(8'h04, gw(FN_OR, 1'b0, 1'b0, 7'h03, 7'h04, 7'h05));
        wr(8'h08, gw(FN_EQUAL, 1'b0, 1'b0, 7'h03, 7'h04, 7'h05));
        wr(8'h0C, gw(FN_UNEQUAL, 1'b0, 1'b0, 7'h03, 7'h04, SRC_UNUSED));
        wr(8'h10, gw(FN_AND, 1'b1, 1'b1, 7'h03, SRC_HIGH, SRC_DI_BASE));
        wr(ADDR_LATCH_BASE, lw(FN_SET_DOM, 7'h06, 7'h07));
        wr(8'h24, lw(FN_RESET_DOM, 7'h06, 7'h07));
        for (int i = 0; i < 12; i++) begin
            EXT_I[5:3] <= 3'($urandom());
            DI_I <= 5'($urandom());
            repeat (7) @(posedge CLK_I);
            g = {~(EXT_I[3] & ~DI_I[0]), EXT_I[3] ^ EXT_I[4],
                (EXT_I[3] == EXT_I[4]) && (EXT_I[4] == EXT_I[5]), |EXT_I[5:3], &EXT_I[5:3]};
            rd(ADDR_STATE, st(1'b0, 2'b00, 1'b0));
        end
        // Latch pulses, both dominance variants side by side
        drive(2'b01, 2'b00);
        rd(ADDR_STATE, st(1'b0, 2'b11, 1'b0));
        drive(2'b10, 2'b00);
        rd(ADDR_STATE, st(1'b0, 2'b00, 1'b0));
        drive(2'b11, 2'b00);
        rd(ADDR_STATE, st(1'b0, 2'b01, 1'b0));
        drive(2'b10, 2'b10);
        rd(ADDR_STATE, st(1'b0, 2'b00, 1'b0));
        drive(2'b11, 2'b00);
        rd(ADDR_STATE, st(1'b0, 2'b01, 1'b0));
        drive(2'b01, 2'b01);
        rd(ADDR_STATE, st(1'b0, 2'b11, 1'b0));
        drive(2'b11, 2'b01);
        rd(ADDR_STATE, st(1'b0, 2'b01, 1'b0));
        // Clock enable low: a reset pulse in the frozen span is never seen
        CE_I <= 1'b0;
        EXT_I[7:6] <= 2'b10;
        repeat (3) @(posedge CLK_I);
        EXT_I[7:6] <= 2'b01;
        repeat (2) @(posedge CLK_I);
        CE_I <= 1'b1;
        wr(ADDR_GATE_BASE, gw(FN_AND, 1'b0, 1'b0, SRC_HIGH, SRC_HIGH, SRC_UNUSED));
        g[0] = 1'b1;
        rd(ADDR_STATE, st(1'b0, 2'b01, 1'b0));
        // Reset in mid-run drops latches and configuration
        RST_I <= 1'b1;
        repeat (2) @(posedge CLK_I);
        RST_I <= 1'b0;
        @(posedge CLK_I);
        g = 5'h00;
        rd(ADDR_STATE, st(1'b0, 2'b00, 1'b0));
        rd(8'h10, 34'h2);
        rd(8'h24, 34'h2);
        repeat (2) @(posedge CLK_I);
        test_done();
    end
endmodule : tb_logic_net
